/* File: sccs_params.svh */
// register map, field positions, codes and counts of the system clock source select block
`ifndef SCCS_PARAMS_SVH
`define SCCS_PARAMS_SVH

// ****************************************
// register offsets
// ****************************************
`define SCCS_OFS_CTRL1 8'h00
`define SCCS_OFS_CTRL2 8'h04
`define SCCS_OFS_CTRL3 8'h08
`define SCCS_OFS_FREQ 8'h0C
`define SCCS_OFS_INT_STAT 8'h10
`define SCCS_OFS_INT_CLR 8'h14
`define SCCS_OFS_INT_EN 8'h18
`define SCCS_OFS_CFG 8'h1C

// ****************************************
// field positions
// ****************************************
`define SCCS_SRC_LSB 4
`define SCCS_DIV_LSB 0
`define SCCS_HOLD_BIT 7
`define SCCS_SWITCH_COMPLETE_FLAG_BIT 4
`define SCCS_NOSR_BIT 3
`define SCCS_CFG_EXT_LSB 4
`define SCCS_CFG_RST_LSB 0
`define SCCS_CFG_CLKOUT_BIT 8

// ****************************************
// source codes
// ****************************************
`define SCCS_SRC_HF_PLL 3'h0
`define SCCS_SRC_EXT_PLL 3'h1
`define SCCS_SRC_EXT 3'h2
`define SCCS_SRC_LF 3'h5
`define SCCS_SRC_HF 3'h6

// ****************************************
// external mode codes
// ****************************************
`define SCCS_EXT_ECH 3'h7
`define SCCS_EXT_ECM 3'h6
`define SCCS_EXT_ECL 3'h5
`define SCCS_EXT_OFF 3'h4
`define SCCS_EXT_HS 3'h2
`define SCCS_EXT_XT 3'h1
`define SCCS_EXT_LP 3'h0

// ****************************************
// frequency codes: 1,2,4,8,12,16,32,48,64 MHz
// ****************************************
`define SCCS_FREQ_MAX 4'h8
`define SCCS_FREQ_PLL_MAX 4'h5
`define SCCS_FREQ_RESET 4'h2
`define SCCS_DIV_RESET 4'h0

// ****************************************
// interrupt events
// ****************************************
`define SCCS_EV_DONE 0
`define SCCS_EV_HOLD 1
`define SCCS_EV_BAD 2
`define SCCS_EV_STOP 3
`define SCCS_EV_W 4

// ****************************************
// timing counts in pclk cycles or pin edges
// ****************************************
`define SCCS_OST_EDGES 1024
`define SCCS_ACT_TIMEOUT 64
`define SCCS_GATE_CYCLES 2

`endif

/* File: sccs_pkg.sv */
// types shared by the system clock source select block
package sccs_pkg;
	// ****************************************
	// switch sequencer states
	// ****************************************
	typedef enum logic [4:0] {
		ST_IDLE = 5'b00001,
		ST_WAIT_RDY = 5'b00010,
		ST_HOLD = 5'b00100,
		ST_GATE_OFF = 5'b01000,
		ST_GATE_ON = 5'b10000
	} sccs_state_t;

	// ****************************************
	// carriers
	// ****************************************
	typedef struct packed {
		logic clkout_en;
		logic [2:0] external_source;
		logic [2:0] reset_source;
	} sccs_cfg_t;

	typedef struct packed {
		logic [2:0] source;
		logic [3:0] div;
	} sccs_sel_t;

	typedef struct packed {
		logic xtal_en;
		logic [1:0] xtal_gain;
		logic ec_en;
		logic [1:0] ec_power;
	} sccs_drive_t;
endpackage

/* File: sccs_clkout_div.sv */
// divide-by-four clock output generator
`timescale 1ns/1ps
module sccs_clkout_div
	import sccs_pkg::*;
(
	// clock and reset
	input wire logic pclk,
	input wire logic presetn,
	// control and output
	input wire logic enable,
	output logic clk_out
);
	logic [1:0] phase;

	// output is a flop so the pin never sees decode glitches
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			phase <= 2'h0;
			clk_out <= 1'b0;
		end else if (enable) begin
			phase <= phase + 2'h1;
			clk_out <= ~phase[1];
		end else begin
			phase <= 2'h0;
			clk_out <= 1'b0;
		end
	end
endmodule

/* File: sccs_top.sv */
// system clock source select: apb registers, switch sequencer, pin monitor and clock output
`timescale 1ns/1ps
`include "sccs_params.svh"
module sccs_top
	import sccs_pkg::*;
#(
	parameter int OST_EDGES = `SCCS_OST_EDGES,
	parameter int ACT_TIMEOUT = `SCCS_ACT_TIMEOUT,
	parameter int GATE_CYCLES = `SCCS_GATE_CYCLES
) (
	// clock and reset
	input wire logic pclk,
	input wire logic presetn,
	// apb slave
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	// configuration words
	input wire sccs_cfg_t cfg,
	// oscillator pins and analog status
	input wire logic osc_in_pin,
	input wire logic hf_ready_in,
	input wire logic lf_ready_in,
	input wire logic pll_lock_in,
	output logic osc_out_pin,
	output logic osc_out_oe,
	// clock tree control
	output sccs_sel_t clk_sel,
	output logic clk_gate_en,
	output logic [3:0] hf_freq,
	output logic pll_enable,
	output sccs_drive_t ext_drive,
	output logic core_halt,
	output logic irq
);
	localparam int OW = $clog2(OST_EDGES + 1);
	localparam int AW = $clog2(ACT_TIMEOUT + 1);
	localparam int GW = $clog2(GATE_CYCLES + 1);

	if (OST_EDGES < 1 || ACT_TIMEOUT < 2 || GATE_CYCLES < 1) begin : g_bad
		$error("sccs_top: counts out of range");
	end

	// ****************************************
	// helpers
	// ****************************************
	function automatic logic src_valid(input logic [2:0] s);
		return s == `SCCS_SRC_HF_PLL || s == `SCCS_SRC_EXT_PLL || s == `SCCS_SRC_EXT ||
			s == `SCCS_SRC_LF || s == `SCCS_SRC_HF;
	endfunction

	function automatic logic uses_pll(input logic [2:0] s);
		return s == `SCCS_SRC_HF_PLL || s == `SCCS_SRC_EXT_PLL;
	endfunction

	function automatic logic uses_ext(input logic [2:0] s);
		return s == `SCCS_SRC_EXT || s == `SCCS_SRC_EXT_PLL;
	endfunction

	function automatic logic pll_input_ok(input logic [3:0] f);
		return f <= `SCCS_FREQ_PLL_MAX;
	endfunction

	// ****************************************
	// synchronisers
	// ****************************************
	logic [3:0] sync1, sync2;
	logic osc_prev;
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			sync1 <= 4'h0;
			sync2 <= 4'h0;
			osc_prev <= 1'b0;
		end else begin
			sync1 <= {pll_lock_in, lf_ready_in, hf_ready_in, osc_in_pin};
			sync2 <= sync1;
			osc_prev <= sync2[0];
		end
	end
	wire osc_edge = sync2[0] & ~osc_prev;
	wire hf_rdy = sync2[1];
	wire lf_rdy = sync2[2];
	wire pll_lock = sync2[3];

	// ****************************************
	// apb slave, one wait state
	// ****************************************
	logic cfg_loaded, hold;
	logic [3:0] freq;
	sccs_sel_t next_sel;
	logic [`SCCS_EV_W-1:0] int_stat, int_en, ev;
	sccs_state_t state;
	logic switch_complete_flag;
	wire access = psel & penable & pready;
	wire wr = access & pwrite;
	wire [2:0] wsrc = pwdata[`SCCS_SRC_LSB +: 3];
	wire wr_ctrl1 = wr && paddr == `SCCS_OFS_CTRL1;
	wire wr_freq = wr && paddr == `SCCS_OFS_FREQ;
	wire ctrl1_ok = src_valid(wsrc) && (wsrc != `SCCS_SRC_HF_PLL || pll_input_ok(freq));
	wire freq_ok = pwdata[3:0] <= `SCCS_FREQ_MAX && (!uses_pll(next_sel.source) ||
		next_sel.source != `SCCS_SRC_HF_PLL || pll_input_ok(pwdata[3:0]));
	wire nosr = state == ST_HOLD || state == ST_GATE_OFF;

	function automatic logic mapped(input logic [7:0] a);
		return a <= `SCCS_OFS_CFG && a[1:0] == 2'h0;
	endfunction

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pready <= 1'b0;
			pslverr <= 1'b0;
			prdata <= 32'h0;
		end else begin
			pready <= psel & penable & ~pready;
			pslverr <= psel & penable & ~pready & ~mapped(paddr);
			prdata <= 32'h0;
			if (psel & penable & ~pready & ~pwrite) begin
				unique case (paddr)
					`SCCS_OFS_CTRL1: prdata <= 32'(next_sel) << `SCCS_DIV_LSB;
					`SCCS_OFS_CTRL2: prdata <= 32'(clk_sel) << `SCCS_DIV_LSB;
					`SCCS_OFS_CTRL3: prdata <= (32'(hold) << `SCCS_HOLD_BIT) |
						(32'(switch_complete_flag) << `SCCS_SWITCH_COMPLETE_FLAG_BIT) | (32'(nosr) << `SCCS_NOSR_BIT);
					`SCCS_OFS_FREQ: prdata <= 32'(freq);
					`SCCS_OFS_INT_STAT: prdata <= 32'(int_stat);
					`SCCS_OFS_INT_EN: prdata <= 32'(int_en);
					`SCCS_OFS_CFG: prdata <= (32'(cfg.clkout_en) << `SCCS_CFG_CLKOUT_BIT) |
						(32'(cfg.external_source) << `SCCS_CFG_EXT_LSB) |
						(32'(cfg.reset_source) << `SCCS_CFG_RST_LSB);
					default: prdata <= 32'h0;
				endcase
			end
		end
	end

	// ****************************************
	// control registers
	// ****************************************
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			cfg_loaded <= 1'b0;
			next_sel <= '{source: `SCCS_SRC_HF, div: `SCCS_DIV_RESET};
			freq <= `SCCS_FREQ_RESET;
			hold <= 1'b0;
			int_en <= '0;
		end else begin
			cfg_loaded <= 1'b1;
			if (!cfg_loaded) begin
				next_sel.source <= cfg.reset_source;
			end else if (wr_ctrl1 && ctrl1_ok) begin
				next_sel <= '{source: wsrc, div: pwdata[`SCCS_DIV_LSB +: 4]};
			end
			if (wr_freq && freq_ok) begin
				freq <= pwdata[3:0];
			end
			if (wr && paddr == `SCCS_OFS_CTRL3) begin
				hold <= pwdata[`SCCS_HOLD_BIT];
			end
			if (wr && paddr == `SCCS_OFS_INT_EN) begin
				int_en <= pwdata[`SCCS_EV_W-1:0];
			end
		end
	end

	// ****************************************
	// external pin monitor and startup timer
	// ****************************************
	logic [AW-1:0] idle_cnt;
	logic [OW-1:0] ost_cnt;
	logic ext_active;
	wire ec_mode = cfg.external_source == `SCCS_EXT_ECH || cfg.external_source == `SCCS_EXT_ECM ||
		cfg.external_source == `SCCS_EXT_ECL;
	wire xtal_mode = cfg.external_source == `SCCS_EXT_HS || cfg.external_source == `SCCS_EXT_XT ||
		cfg.external_source == `SCCS_EXT_LP;
	wire ost_done = ost_cnt == OW'(OST_EDGES);
	wire ext_ok = ext_active & (ec_mode | (xtal_mode & ost_done));

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			idle_cnt <= '0;
			ext_active <= 1'b0;
			ost_cnt <= '0;
		end else begin
			if (osc_edge) begin
				idle_cnt <= '0;
				ext_active <= 1'b1;
			end else if (idle_cnt == AW'(ACT_TIMEOUT)) begin
				ext_active <= 1'b0;
			end else begin
				idle_cnt <= idle_cnt + AW'(1);
			end
			// timer restarts whenever the crystal stalls
			if (!xtal_mode || (!ext_active && !osc_edge)) begin
				ost_cnt <= '0;
			end else if (osc_edge && !ost_done) begin
				ost_cnt <= ost_cnt + OW'(1);
			end
		end
	end

	function automatic logic src_ready(input logic [2:0] s);
		unique case (s)
			`SCCS_SRC_HF: return hf_rdy;
			`SCCS_SRC_LF: return lf_rdy;
			`SCCS_SRC_EXT: return ext_ok;
			`SCCS_SRC_EXT_PLL: return ext_ok & pll_lock;
			`SCCS_SRC_HF_PLL: return hf_rdy & pll_lock;
			default: return 1'b0;
		endcase
	endfunction

	// ****************************************
	// switch sequencer
	// ****************************************
	logic [GW-1:0] gate_cnt;
	wire halted = uses_ext(clk_sel.source) & ~ext_active & cfg_loaded;
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			state <= ST_IDLE;
			clk_sel <= '{source: `SCCS_SRC_HF, div: `SCCS_DIV_RESET};
			clk_gate_en <= 1'b1;
			gate_cnt <= '0;
		end else if (!cfg_loaded) begin
			clk_sel.source <= cfg.reset_source;
		end else begin
			unique case (state)
				ST_IDLE: if (next_sel != clk_sel) state <= ST_WAIT_RDY;
				ST_WAIT_RDY: if (src_ready(next_sel.source)) state <= hold ? ST_HOLD : ST_GATE_OFF;
				ST_HOLD: if (!hold) state <= ST_GATE_OFF;
				ST_GATE_OFF: begin
					clk_gate_en <= 1'b0;
					gate_cnt <= gate_cnt + GW'(1);
					if (gate_cnt == GW'(GATE_CYCLES)) begin
						clk_sel <= next_sel;
						gate_cnt <= '0;
						state <= ST_GATE_ON;
					end
				end
				ST_GATE_ON: begin
					clk_gate_en <= 1'b1;
					state <= ST_IDLE;
				end
			endcase
		end
	end

	// ****************************************
	// outputs and interrupts
	// ****************************************
	always_comb begin
		ev = '0;
		ev[`SCCS_EV_DONE] = state == ST_GATE_ON;
		ev[`SCCS_EV_HOLD] = state == ST_WAIT_RDY && hold && src_ready(next_sel.source);
		ev[`SCCS_EV_BAD] = (wr_ctrl1 && !ctrl1_ok) || (wr_freq && !freq_ok);
		ev[`SCCS_EV_STOP] = halted & ~core_halt;
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			int_stat <= '0;
			irq <= 1'b0;
		end else begin
			// a new event wins over a clear in the same cycle
			int_stat <= (int_stat & ~((wr && paddr == `SCCS_OFS_INT_CLR) ? pwdata[`SCCS_EV_W-1:0] :
				'0)) | ev;
			irq <= |(int_stat & int_en);
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			switch_complete_flag <= 1'b0;
			core_halt <= 1'b0;
			hf_freq <= `SCCS_FREQ_RESET;
			pll_enable <= 1'b0;
			ext_drive <= '0;
			osc_out_oe <= 1'b0;
		end else begin
			switch_complete_flag <= cfg_loaded && next_sel == clk_sel;
			core_halt <= halted;
			hf_freq <= freq;
			pll_enable <= uses_pll(next_sel.source) | uses_pll(clk_sel.source);
			ext_drive.ec_en <= ec_mode;
			ext_drive.ec_power <= cfg.external_source[1:0];
			ext_drive.xtal_en <= xtal_mode;
			ext_drive.xtal_gain <= cfg.external_source[1:0];
			osc_out_oe <= cfg_loaded & cfg.clkout_en & ~xtal_mode;
		end
	end

	sccs_clkout_div u_clkout (
		.pclk(pclk),
		.presetn(presetn),
		.enable(osc_out_oe),
		.clk_out(osc_out_pin)
	);

	// ****************************************
	// assertions
	// ****************************************
	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);

	a_freq_range: assert property (wr_freq && pwdata[3:0] > `SCCS_FREQ_MAX |=> $stable(freq))
		else $error("frequency code out of range was stored");
	a_pll_input: assert property (clk_sel.source == `SCCS_SRC_HF_PLL && cfg_loaded |-> pll_input_ok(freq))
		else $error("multiplier fed by a too fast internal oscillator");
	a_bad_source: assert property (cfg_loaded && wr_ctrl1 && !src_valid(wsrc) |=>
		$stable(next_sel) && int_stat[`SCCS_EV_BAD])
		else $error("illegal source accepted");
	a_pin_free: assert property (osc_out_oe |-> !ext_drive.xtal_en)
		else $error("clock out driven in crystal mode");
	a_quarter_rate: assert property ($rose(osc_out_pin) && osc_out_oe |=>
		osc_out_pin ##1 !osc_out_pin ##1 !osc_out_pin)
		else $error("clock out not a quarter rate");
	a_reset_source: assert property ($rose(cfg_loaded) |-> clk_sel.source == $past(cfg.reset_source))
		else $error("reset source not taken from configuration");
	a_switch_start: assert property (cfg_loaded && wr_ctrl1 && ctrl1_ok && state == ST_IDLE && next_sel == clk_sel &&
		wsrc != clk_sel.source |=> ##1 !switch_complete_flag)
		else $error("write did not start a switch");
	a_no_ost_ec: assert property (ec_mode && ext_active |-> ext_ok)
		else $error("startup delay applied in external input mode");
	a_halt_keep: assert property (core_halt && state == ST_IDLE |=> $stable(clk_sel))
		else $error("state changed while halted");
	a_hold_wait: assert property (state == ST_HOLD && hold |=> state == ST_HOLD && clk_gate_en)
		else $error("switch proceeded under hold");
	a_gate_swap: assert property (clk_sel != $past(clk_sel) && $past(cfg_loaded) |->
		!clk_gate_en && $past(!clk_gate_en))
		else $error("source swapped with clock running");

	c_switch_done: cover property (state == ST_GATE_ON);
	c_hold_release: cover property (state == ST_HOLD ##[1:100] state == ST_GATE_OFF);
	c_ext_halt: cover property ($rose(core_halt));
	c_pll_reject: cover property (wr_ctrl1 && !ctrl1_ok);
endmodule

/* File: sccs_osc_model.sv */
// behavioural external oscillator module and analog ready sources
`timescale 1ns/1ps
module sccs_osc_model #(
	parameter int HALF_NS = 85
) (
	// control from the bench
	input wire logic run,
	// pins and status toward the block
	output logic osc_in_pin,
	output logic hf_ready_in,
	output logic lf_ready_in,
	output logic pll_lock_in
);
	// ****************************************
	// ready levels
	// ****************************************
	// sources start not ready and come up at 120 ns, just before the bench releases reset, like real analog blocks
	initial begin
		hf_ready_in = 1'b0;
		lf_ready_in = 1'b0;
		pll_lock_in = 1'b0;
		#120;
		hf_ready_in = 1'b1;
		lf_ready_in = 1'b1;
		pll_lock_in = 1'b1;
	end

	// ****************************************
	// logic-level clock
	// ****************************************
	// stands low while stopped, so a halted core sees no edges at all
	always begin
		#HALF_NS;
		osc_in_pin = run ? ~osc_in_pin : 1'b0;
	end
endmodule

/* File: tb.sv */
// self-checking bench of the system clock source select block
`timescale 1ns/1ps
`include "sccs_params.svh"
`define CHK(nm, e, a) begin n_tests++; if ((a) !== (e)) begin errors++; \
	$display("[ERR] %s exp %0h got %0h", nm, e, a); end end
`define WAIT(c, m) begin n = 0; while ((c) !== 1'b1 && n < m) begin @(negedge pclk); n++; end end
module tb import sccs_pkg::*;;
	logic pclk = 0;
	logic presetn = 0;
	logic psel = 0;
	logic penable = 0;
	logic pwrite = 0;
	logic run = 0;
	logic [7:0] paddr = 0;
	logic [31:0] pwdata = 0;
	logic [31:0] prdata, rdv;
	logic pready, pslverr, rerr, osc_in_pin, hf_rdy, lf_rdy, pll_lock;
	logic oout, ooe, gate, pll_en, halt, irq, p;
	logic [3:0] hf_freq;
	sccs_cfg_t cfg = '0;
	sccs_sel_t clk_sel;
	sccs_drive_t ext_drive;
	int errors = 0;
	int n_tests = 0;
	int cyc = 0;
	int i, n, k;

	always #25 pclk = ~pclk;

	// short counts keep the run brief; startup timer left long to expose a missing bypass
	sccs_top #(.OST_EDGES(64), .ACT_TIMEOUT(8), .GATE_CYCLES(2)) sccs_top_inst (.pclk(pclk), .presetn(presetn),
		.psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
		.pready(pready), .pslverr(pslverr), .cfg(cfg), .osc_in_pin(osc_in_pin), .hf_ready_in(hf_rdy),
		.lf_ready_in(lf_rdy), .pll_lock_in(pll_lock), .osc_out_pin(oout), .osc_out_oe(ooe), .clk_sel(clk_sel),
		.clk_gate_en(gate), .hf_freq(hf_freq), .pll_enable(pll_en), .ext_drive(ext_drive), .core_halt(halt),
		.irq(irq));
	sccs_osc_model #(.HALF_NS(85)) sccs_osc_model_inst (.run(run), .osc_in_pin(osc_in_pin),
		.hf_ready_in(hf_rdy), .lf_ready_in(lf_rdy), .pll_lock_in(pll_lock));

	// ****************************************
	// bus and reset tasks
	// ****************************************
	task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
		@(posedge pclk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= wr;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		// no cycle limit here: the bench's cycle ceiling ends a hung transfer
		do begin
			@(posedge pclk);
		end while (pready !== 1'b1);
		rdv = prdata;
		rerr = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask

	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		apb(1'b1, a, d);
	endtask

	task automatic rd(input logic [7:0] a);
		apb(1'b0, a, 32'h0);
	endtask

	task automatic do_reset(input sccs_cfg_t c);
		@(posedge pclk);
		presetn <= 1'b0;
		cfg <= c;
		repeat (2) @(posedge pclk);
		presetn <= 1'b1;
		repeat (3) @(negedge pclk);
	endtask

	// ****************************************
	// scenarios
	// ****************************************
	task automatic t_reset;
		do_reset(7'h7D);
		`CHK("src", 3'h5, clk_sel.source);
		`CHK("gate", 1'b1, gate);
		`CHK("freq", 4'h2, hf_freq);
		rd(`SCCS_OFS_CTRL2);
		`CHK("cur", 32'h50, rdv);
		rd(`SCCS_OFS_CTRL3);
		`CHK("ctrl3", 32'h10, rdv);
		rd(`SCCS_OFS_CFG);
		`CHK("cfg", 32'h175, rdv);
		rd(8'h20);
		`CHK("unmapped err", 1'b1, rerr);
		`CHK("unmapped data", 32'h0, rdv);
		$display("test reset done");
	endtask

	task automatic t_freq;
		for (i = 0; i <= 8; i++) begin
			wr(`SCCS_OFS_FREQ, i);
			rd(`SCCS_OFS_FREQ);
			`CHK("freq rd", i, rdv);
			`CHK("freq out", i[3:0], hf_freq);
		end
		wr(`SCCS_OFS_FREQ, 32'h9);
		rd(`SCCS_OFS_FREQ);
		`CHK("freq bad rd", 32'h8, rdv);
		`CHK("freq bad", 4'h8, hf_freq);
		wr(`SCCS_OFS_CTRL1, 32'h0);
		rd(`SCCS_OFS_CTRL1);
		`CHK("pll refused", 32'h50, rdv);
		wr(`SCCS_OFS_CTRL1, 32'h30);
		rd(`SCCS_OFS_CTRL1);
		`CHK("src refused", 32'h50, rdv);
		rd(`SCCS_OFS_INT_STAT);
		`CHK("stat bad", 32'h4, rdv);
		wr(`SCCS_OFS_INT_CLR, 32'h4);
		rd(`SCCS_OFS_INT_STAT);
		`CHK("stat clr", 32'h0, rdv);
		// multiplier behind the internal oscillator only at slow input codes
		wr(`SCCS_OFS_FREQ, 32'h5);
		wr(`SCCS_OFS_CTRL1, 32'h0);
		`WAIT(clk_sel === 7'h00, 30);
		`CHK("hf pll", 7'h00, clk_sel);
		`CHK("hf pll on", 1'b1, pll_en);
		wr(`SCCS_OFS_FREQ, 32'h6);
		rd(`SCCS_OFS_FREQ);
		`CHK("pll freq refused", 32'h5, rdv);
		wr(`SCCS_OFS_INT_CLR, 32'h5);
		$display("test freq done");
	endtask

	task automatic t_switch;
		wr(`SCCS_OFS_INT_EN, 32'hF);
		wr(`SCCS_OFS_CTRL1, 32'h63);
		`WAIT(gate === 1'b0, 30);
		`CHK("gate off", 1'b0, gate);
		`WAIT(gate === 1'b1, 10);
		`CHK("gate len", 3, n);
		`CHK("sel", 7'h63, clk_sel);
		`WAIT(irq === 1'b1, 5);
		`CHK("irq", 1'b1, irq);
		rd(`SCCS_OFS_CTRL3);
		`CHK("switch_complete_flag", 32'h10, rdv);
		rd(`SCCS_OFS_CTRL2);
		`CHK("cur", 32'h63, rdv);
		rd(`SCCS_OFS_INT_STAT);
		`CHK("stat done", 32'h1, rdv);
		wr(`SCCS_OFS_INT_CLR, 32'h1);
		repeat (2) @(negedge pclk);
		`CHK("irq clr", 1'b0, irq);
		$display("test switch done");
	endtask

	task automatic t_hold;
		wr(`SCCS_OFS_INT_EN, 32'h1);
		wr(`SCCS_OFS_CTRL3, 32'h80);
		wr(`SCCS_OFS_CTRL1, 32'h50);
		repeat (20) @(negedge pclk);
		`CHK("held", 7'h63, clk_sel);
		`CHK("masked", 1'b0, irq);
		rd(`SCCS_OFS_CTRL3);
		`CHK("ctrl3 held", 32'h88, rdv);
		rd(`SCCS_OFS_INT_STAT);
		`CHK("stat hold", 32'h2, rdv);
		wr(`SCCS_OFS_CTRL3, 32'h0);
		`WAIT(clk_sel === 7'h50, 40);
		`CHK("released", 7'h50, clk_sel);
		`WAIT(irq === 1'b1, 5);
		`CHK("irq done", 1'b1, irq);
		wr(`SCCS_OFS_INT_CLR, 32'h3);
		$display("test hold done");
	endtask

	task automatic t_ext;
		run <= 1'b1;
		wr(`SCCS_OFS_CTRL1, 32'h20);
		`WAIT(clk_sel.source === 3'h2, 60);
		`CHK("ext src", 3'h2, clk_sel.source);
		`CHK("no ost", 1'b1, n < 40);
		`CHK("ec en", 1'b1, ext_drive.ec_en);
		`CHK("ec pwr", 2'h3, ext_drive.ec_power);
		`CHK("oe", 1'b1, ooe);
		k = 0;
		p = oout;
		repeat (40) begin
			@(negedge pclk);
			if (oout === 1'b1 && p === 1'b0)
				k++;
			p = oout;
		end
		`CHK("clkout rises", 10, k);
		run <= 1'b0;
		`WAIT(halt === 1'b1, 30);
		`CHK("halt", 1'b1, halt);
		rd(`SCCS_OFS_INT_STAT);
		`CHK("stat stop", 1'b1, rdv[3]);
		run <= 1'b1;
		`WAIT(halt === 1'b0, 30);
		`CHK("resume", 1'b0, halt);
		`CHK("kept", 3'h2, clk_sel.source);
		wr(`SCCS_OFS_CTRL1, 32'h10);
		`WAIT(clk_sel.source === 3'h1, 300);
		`CHK("pll src", 3'h1, clk_sel.source);
		`CHK("pll on", 1'b1, pll_en);
		$display("test ext done");
	endtask

	task automatic t_modes;
		for (i = 0; i < 8; i++) begin
			if (i == 3)
				continue;
			@(posedge pclk);
			cfg.external_source <= i[2:0];
			repeat (3) @(negedge pclk);
			`CHK("ec en", i >= 5, ext_drive.ec_en);
			`CHK("xtal en", i <= 2, ext_drive.xtal_en);
			`CHK("oe mode", i >= 4, ooe);
			if (i >= 5) begin
				`CHK("ec pwr", i[1:0], ext_drive.ec_power);
			end else begin
				`CHK("gain", i[1:0], ext_drive.xtal_gain);
			end
		end
		// a crystal source waits for the startup timer before the swap
		@(posedge pclk);
		cfg.external_source <= 3'h2;
		wr(`SCCS_OFS_CTRL1, 32'h20);
		repeat (20) @(negedge pclk);
		`CHK("ost wait", 3'h1, clk_sel.source);
		`WAIT(clk_sel.source === 3'h2, 400);
		`CHK("xtal src", 3'h2, clk_sel.source);
		$display("test modes done");
	endtask

	// ****************************************
	// run control
	// ****************************************
	task automatic tally_and_finish;
		$display("comparisons %0d mismatches %0d", n_tests, errors);
		if (errors == 0 && n_tests > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask

	always @(posedge pclk) begin
		cyc++;
		if (cyc == 20000) begin
			errors++;
			tally_and_finish();
		end
	end

	initial begin
		t_reset();
		t_freq();
		t_switch();
		t_hold();
		t_ext();
		t_modes();
		tally_and_finish();
	end
endmodule
